// ---- pcrr_defines.vh ----
/*
 constants for the clock-run request block: register offsets, field positions,
 reset values and timing counts. assumes inclusion by the design file and the bench.
*/
`ifndef PCRR_DEFINES_VH
`define PCRR_DEFINES_VH
`define PCRR_OFF_CTRL        12'h03c
`define PCRR_OFF_IRQ_STATUS  12'h100
`define PCRR_OFF_IRQ_ENABLE  12'h104
`define PCRR_OFF_IRQ_CLEAR   12'h108
`define PCRR_BIT_WAKE_STS    15
`define PCRR_BIT_WAKE_EN     8
`define PCRR_BIT_CLKRUN_EN   0
`define PCRR_CTRL_RESET      32'h0000_0000
`define PCRR_IRQ_WAKE        0
`define PCRR_IRQ_START       1
`define PCRR_IRQ_CONTINUE    2
`define PCRR_IRQ_RELEASE     3
`define PCRR_IRQ_W           4
`define PCRR_EDGES_HOLD      2'd2
`define PCRR_EDGES_IDLE      2'd2
`define PCRR_RESP_OKAY       2'b00
`define PCRR_RESP_SLVERR     2'b10
`endif

// ---- pcrr_top.v ----
/*
 clock-run / wake request logic with its control register over axi4-lite.
 assumes the shared pin is open drain with an external pull-up, and that the
 pci clock arrives as a plain input sampled by aclk (much slower than aclk).
*/
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Notes on behaviour
// - wake status bit 15 is sticky, set regardless of enable in plain wake mode, cleared writing one
// - pin may assert only with wake enable bit 8 set, else held inactive
// - wake enable loadable from configuration memory during auto load
// - bits 15 and 8 mirror the config-space power management register identically
// - clock-run enable bit 0 selects clock-run handshake or plain wake output
// - clock-run output is open drain: only pulls low, never drives high
// - in clock-run mode, pin is input except when requesting clock start or continue
// - system releases signal high while transfer pending: assert to continue clock
// - clock stopped: assert for wake packet or receive data awaiting transfer
// - hold assertion until two rising pci clock edges seen, then release
// - assert only after signal sampled high on two consecutive pci edges
// - after completion, never block clock stop even with pending interrupt
// - wake enable clear forbids any clock start or continue request
// - receive clock mux follows the signal: pci clock when low, crystal when high (here only in clock-run mode; plain wake mode always selects pci clock)
`include "pcrr_defines.vh"
module pcrr_top (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite slave
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // config-space mirror of the power management register
    input  wire        cfg_wr,
    input  wire        cfg_wake_status_clr,
    input  wire        cfg_wake_enable,
    output reg         power_mgmt_wake_status,
    output reg         power_mgmt_wake_enable,
    // configuration memory auto load
    input  wire        autoload_valid,
    input  wire        autoload_wake_enable,
    // internal events
    input  wire        wake_on_lan_state,
    input  wire        wake_packet,
    input  wire        xfer_pending,
    input  wire        rx_data_ready,
    // pci clock sampled as data, shared open-drain pin
    input  wire        pci_clk,
    input  wire        clock_run_signal_in,
    output reg         clock_run_signal_out,
    output reg         clock_run_signal_oe,
    // receive clock mux select: 1 selects the crystal reference clock
    output reg         rx_clk_sel_crystal,
    // interrupt
    output reg         irq
);
    localparam ST_IDLE   = 3'b001;
    localparam ST_ASSERT = 3'b010;
    localparam ST_DONE   = 3'b100;

    reg        wake_status_reg;
    reg        wake_enable_reg;
    reg        clkrun_en_reg;
    reg [`PCRR_IRQ_W-1:0] irq_status_reg;
    reg [`PCRR_IRQ_W-1:0] irq_enable_reg;
    reg [`PCRR_IRQ_W-1:0] irq_event;
    reg [2:0]  pclk_sync_reg;
    reg [2:0]  crun_sync_reg;
    reg        pclk_level_reg;
    reg        crun_level_reg;
    reg [1:0]  high_cnt_reg;
    reg [1:0]  edge_cnt_reg;
    reg [2:0]  state_reg;
    reg        start_kind_reg;
    reg        aw_held_reg;
    reg        w_held_reg;
    reg [11:0] awaddr_reg;
    reg [31:0] wdata_reg;
    reg [3:0]  wstrb_reg;
    wire       pclk_rise;
    wire       want_start;
    wire       want_cont;
    wire       do_write;
    wire       wr_ctrl;
    wire       wr_clr;
    wire       wr_en;
    wire [31:0] ctrl_word;

    // three-stage sampling, a level changes once stages two and three agree
    always @(posedge aclk) begin
        if (!aresetn) begin
            pclk_sync_reg  <= 3'h0;
            crun_sync_reg  <= 3'h7;
            pclk_level_reg <= 1'b0;
            crun_level_reg <= 1'b1;
        end else begin
            pclk_sync_reg <= {pclk_sync_reg[1:0], pci_clk};
            crun_sync_reg <= {crun_sync_reg[1:0], clock_run_signal_in};
            if (pclk_sync_reg[1] == pclk_sync_reg[2])
                pclk_level_reg <= pclk_sync_reg[2];
            if (crun_sync_reg[1] == crun_sync_reg[2])
                crun_level_reg <= crun_sync_reg[2];
        end
    end
    assign pclk_rise = pclk_sync_reg[1] & pclk_sync_reg[2] & ~pclk_level_reg;

    // the clock still runs when the pin is first released, so both kinds see two idle edges
    assign want_start = wake_enable_reg & clkrun_en_reg & crun_level_reg &
                        ((wake_on_lan_state & wake_packet) | rx_data_ready);
    assign want_cont  = wake_enable_reg & clkrun_en_reg & crun_level_reg &
                        xfer_pending;

    // handshake state machine
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_reg      <= ST_IDLE;
            high_cnt_reg   <= 2'd0;
            edge_cnt_reg   <= 2'd0;
            start_kind_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    edge_cnt_reg <= 2'd0;
                    if (!crun_level_reg)
                        high_cnt_reg <= 2'd0;
                    else if (pclk_rise && high_cnt_reg != `PCRR_EDGES_IDLE)
                        high_cnt_reg <= high_cnt_reg + 2'd1;
                    // the edge count may lag a freshly released pin, never lead it
                    if (high_cnt_reg == `PCRR_EDGES_IDLE && (want_start || want_cont)) begin
                        state_reg      <= ST_ASSERT;
                        start_kind_reg <= ~want_cont;
                    end
                end
                ST_ASSERT: begin
                    if (pclk_rise)
                        edge_cnt_reg <= edge_cnt_reg + 2'd1;
                    if (!wake_enable_reg || !clkrun_en_reg)
                        state_reg <= ST_DONE;
                    else if (pclk_rise && edge_cnt_reg == `PCRR_EDGES_HOLD - 2'd1)
                        state_reg <= ST_DONE;
                end
                ST_DONE: begin
                    // re-arm only after the central resource lets go again
                    high_cnt_reg <= 2'd0;
                    if (crun_level_reg)
                        state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // pin drive: low only, never high
    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_run_signal_out <= 1'b0;
            clock_run_signal_oe  <= 1'b0;
            rx_clk_sel_crystal   <= 1'b0;
        end else begin
            clock_run_signal_out <= 1'b0;
            if (!wake_enable_reg)
                clock_run_signal_oe <= 1'b0;
            else if (clkrun_en_reg)
                clock_run_signal_oe <= (state_reg == ST_ASSERT);
            else
                clock_run_signal_oe <= wake_status_reg;
            rx_clk_sel_crystal <= clkrun_en_reg & crun_level_reg;
        end
    end

    // axi4-lite write: address and data in either order
    assign do_write = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_ctrl  = do_write && awaddr_reg == `PCRR_OFF_CTRL;
    assign wr_en    = do_write && awaddr_reg == `PCRR_OFF_IRQ_ENABLE;
    assign wr_clr   = do_write && awaddr_reg == `PCRR_OFF_IRQ_CLEAR;
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 12'h000;
            wdata_reg     <= 32'h0000_0000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `PCRR_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_reg & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_held_reg & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_ctrl || wr_en || wr_clr) ? `PCRR_RESP_OKAY
                                                             : `PCRR_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // control register; soft reset is not wired here, so only aresetn clears it
    assign ctrl_word = {16'h0000, wake_status_reg, 6'h00, wake_enable_reg, 7'h00, clkrun_en_reg};
    always @(posedge aclk) begin
        if (!aresetn) begin
            wake_status_reg <= 1'b0;
            wake_enable_reg <= 1'b0;
            clkrun_en_reg   <= 1'b0;
        end else begin
            // set wins over either clear path
            if ((state_reg == ST_ASSERT && start_kind_reg) ||
                (!clkrun_en_reg && wake_on_lan_state && wake_packet))
                wake_status_reg <= 1'b1;
            else if ((wr_ctrl && wstrb_reg[1] && wdata_reg[`PCRR_BIT_WAKE_STS]) ||
                     (cfg_wr && cfg_wake_status_clr))
                wake_status_reg <= 1'b0;
            if (autoload_valid)
                wake_enable_reg <= autoload_wake_enable;
            else if (cfg_wr)
                wake_enable_reg <= cfg_wake_enable;
            else if (wr_ctrl && wstrb_reg[1])
                wake_enable_reg <= wdata_reg[`PCRR_BIT_WAKE_EN];
            if (wr_ctrl && wstrb_reg[0])
                clkrun_en_reg <= wdata_reg[`PCRR_BIT_CLKRUN_EN];
        end
    end

    // interrupt status: sticky, set wins over clear
    always @* begin
        irq_event = {`PCRR_IRQ_W{1'b0}};
        irq_event[`PCRR_IRQ_WAKE]     = wake_on_lan_state & wake_packet;
        irq_event[`PCRR_IRQ_START]    = state_reg == ST_IDLE && want_start && !want_cont &&
                                        high_cnt_reg == `PCRR_EDGES_IDLE;
        irq_event[`PCRR_IRQ_CONTINUE] = state_reg == ST_IDLE && want_cont &&
                                        high_cnt_reg == `PCRR_EDGES_IDLE;
        irq_event[`PCRR_IRQ_RELEASE]  = state_reg == ST_ASSERT && pclk_rise &&
                                        edge_cnt_reg == `PCRR_EDGES_HOLD - 2'd1;
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_reg <= {`PCRR_IRQ_W{1'b0}};
            irq_enable_reg <= {`PCRR_IRQ_W{1'b0}};
            irq            <= 1'b0;
            power_mgmt_wake_status <= 1'b0;
            power_mgmt_wake_enable <= 1'b0;
        end else begin
            irq_status_reg <= (irq_status_reg & ~(wr_clr ? wdata_reg[`PCRR_IRQ_W-1:0]
                              : {`PCRR_IRQ_W{1'b0}})) | irq_event;
            if (wr_en)
                irq_enable_reg <= wdata_reg[`PCRR_IRQ_W-1:0];
            irq <= |(irq_status_reg & irq_enable_reg);
            power_mgmt_wake_status <= wake_status_reg;
            power_mgmt_wake_enable <= wake_enable_reg;
        end
    end

    // axi4-lite read
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `PCRR_RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `PCRR_RESP_OKAY;
                if (s_axi_araddr == `PCRR_OFF_CTRL)
                    s_axi_rdata <= ctrl_word;
                else if (s_axi_araddr == `PCRR_OFF_IRQ_STATUS)
                    s_axi_rdata <= {28'h000_0000, irq_status_reg};
                else if (s_axi_araddr == `PCRR_OFF_IRQ_ENABLE)
                    s_axi_rdata <= {28'h000_0000, irq_enable_reg};
                else if (s_axi_araddr == `PCRR_OFF_IRQ_CLEAR)
                    s_axi_rdata <= 32'h0000_0000;
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `PCRR_RESP_SLVERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // pcrr_top

// ---- pcrr_clock_model.sv ----
/* behavioural central clock resource: makes the pci clock and owns the
   pulled-up clock-run pin. assumes the bench resolves the pin level. */
`timescale 1ns/1ns
module pcrr_clock_model (
    // bench asks for the clock to stop
    input  logic stop_req,
    // device pulling the pin low
    input  logic dut_pull,
    // clock and pin drive
    output logic pci_clk,
    output logic drive_low
);
    logic running;
    int   n;
    initial begin
        pci_clk = 1'b0;
        drive_low = 1'b1;
        running = 1'b1;
    end
    // clock stands still low while stopped
    always begin
        #62;
        if (running) pci_clk = 1'b1;
        #63;
        pci_clk = 1'b0;
    end
    initial forever begin
        wait (stop_req);
        drive_low = 1'b0;
        n = 0;
        while (!dut_pull && n < 6) begin
            @(posedge pci_clk);
            n++;
        end
        // nobody objected within six edges, so the clock really stops
        if (!dut_pull) running = 1'b0;
        wait (dut_pull || !stop_req);
        running = 1'b1;
        drive_low = 1'b1;
        repeat (4) @(posedge pci_clk);
        wait (!stop_req);
    end
endmodule // pcrr_clock_model

// ---- pcrr_top_properties.sv ----
/* assertions on the pcrr_top ports for the shared pin and the mirror.
   assumes one aclk domain and a pulled-up pin. */
`timescale 1ns/1ns
module pcrr_top_properties (
    // clock and reset
    input logic aclk,
    input logic aresetn,
    // bus and mirror
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_bvalid,
    input logic cfg_wr,
    input logic power_mgmt_wake_status,
    input logic power_mgmt_wake_enable,
    // shared pin
    input logic clock_run_signal_in,
    input logic clock_run_signal_out,
    input logic clock_run_signal_oe,
    input logic rx_clk_sel_crystal
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // cycles the raw pin has stood released, saturating
    logic [7:0] hi_cnt_reg;
    always @(posedge aclk) begin
        if (!aresetn || !clock_run_signal_in) hi_cnt_reg <= 8'h00;
        else if (hi_cnt_reg != 8'hff) hi_cnt_reg <= hi_cnt_reg + 8'h01;
    end
    sequence req_rise;
        $rose(clock_run_signal_oe) && $past(clock_run_signal_in);
    endsequence
    chk_never_high: assert property (clock_run_signal_oe |-> !clock_run_signal_out)
        else $error("pin driven high");
    chk_enable_gates: assert property (!power_mgmt_wake_enable [*3] |-> !clock_run_signal_oe)
        else $error("pin pulled while wake enable clear");
    chk_status_clear: assert property ($fell(power_mgmt_wake_status) |->
        $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(cfg_wr, 2) || $past(cfg_wr, 3))
        else $error("wake status dropped without a clear");
    chk_hold_min: assert property (req_rise |=> clock_run_signal_oe [*8])
        else $error("request released too early");
    chk_release_max: assert property (req_rise |-> ##[1:120] !clock_run_signal_oe)
        else $error("request not released");
    chk_idle_first: assert property (req_rise |-> $past(hi_cnt_reg) >= 8'h1e)
        else $error("request without idle pin first");
    chk_crystal_follow: assert property ($rose(rx_clk_sel_crystal) |-> $past(clock_run_signal_in, 3))
        else $error("crystal select without released pin");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (req_rise);
    cover property ($rose(rx_clk_sel_crystal));
    cover property ($fell(power_mgmt_wake_status));
endmodule // pcrr_top_properties
bind pcrr_top pcrr_top_properties u_props (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_bvalid, .cfg_wr, .power_mgmt_wake_status, .power_mgmt_wake_enable,
    .clock_run_signal_in, .clock_run_signal_out, .clock_run_signal_oe, .rx_clk_sel_crystal);

// ---- tb_pci_clock_run_request.sv ----
/* self-checking bench for pcrr_top over axi4-lite with a clock resource model.
   assumes the pin is pulled up and resolved here. */
`timescale 1ns/1ns
`include "pcrr_defines.vh"
module tb_pci_clock_run_request;
    localparam logic [11:0] CTRL = `PCRR_OFF_CTRL;
    localparam logic [11:0] STS = `PCRR_OFF_IRQ_STATUS;
    localparam logic [1:0]  OK = `PCRR_RESP_OKAY;
    localparam logic [31:0] EN = 32'h0000_0001 << `PCRR_BIT_WAKE_EN;
    localparam logic [31:0] CR = 32'h0000_0001 << `PCRR_BIT_CLKRUN_EN;
    localparam logic [31:0] ST = 32'h0000_0001 << `PCRR_BIT_WAKE_STS;
    localparam logic [31:0] REL = 32'h0000_0001 << `PCRR_IRQ_RELEASE;
    logic        aclk = 1'b0, aresetn = 1'b0, stop_req = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cfg_wr = 1'b0, cfg_wake_status_clr = 1'b0, cfg_wake_enable = 1'b0;
    logic        autoload_valid = 1'b0, autoload_wake_enable = 1'b0, wake_on_lan_state = 1'b0;
    logic        wake_packet = 1'b0, xfer_pending = 1'b0, rx_data_ready = 1'b0;
    logic        pci_clk, cr_low, clock_run_signal_out, clock_run_signal_oe;
    logic        power_mgmt_wake_status, power_mgmt_wake_enable, rx_clk_sel_crystal, irq;
    int          errors = 0, compares = 0, cyc = 0;
    // open-drain pin with pull-up
    wire         clock_run_signal_in = !(cr_low || (clock_run_signal_oe && !clock_run_signal_out));
    always #2 aclk = ~aclk;
    pcrr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_wr, .cfg_wake_status_clr,
        .cfg_wake_enable, .power_mgmt_wake_status, .power_mgmt_wake_enable, .autoload_valid,
        .autoload_wake_enable, .wake_on_lan_state, .wake_packet, .xfer_pending, .rx_data_ready,
        .pci_clk, .clock_run_signal_in, .clock_run_signal_out, .clock_run_signal_oe,
        .rx_clk_sel_crystal, .irq);
    pcrr_clock_model u_crm (.stop_req, .dut_pull(clock_run_signal_oe), .pci_clk,
        .drive_low(cr_low));
    task automatic end_sim;
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, OK);
        // let an edge pass so a following call never re-drives bready in this step
        @(posedge aclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
        @(posedge aclk);
    endtask
    // bounded wait for the pin request to reach a level
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        while (clock_run_signal_oe !== v && n < 3000) begin
            @(posedge aclk);
            n++;
        end
        chk(clock_run_signal_oe, v);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            end_sim();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CTRL, `PCRR_CTRL_RESET, OK);
        rd(12'h0f0, 32'h0000_0000, `PCRR_RESP_SLVERR);
        autoload_wake_enable <= 1'b1;
        autoload_valid <= 1'b1;
        @(posedge aclk);
        autoload_valid <= 1'b0;
        rd(CTRL, EN, OK);
        wr(CTRL, EN | CR);
        wr(`PCRR_OFF_IRQ_ENABLE, 32'h0000_000f);
        chk(power_mgmt_wake_enable, 1'b1);
        // clock continue: transfer still pending when the pin is released
        xfer_pending <= 1'b1;
        stop_req <= 1'b1;
        wait_oe(1'b1);
        wait_oe(1'b0);
        repeat (4) @(posedge aclk);
        chk(irq, 1'b1);
        rd(STS, (32'h0000_0001 << `PCRR_IRQ_CONTINUE) | REL, OK);
        wr(`PCRR_OFF_IRQ_CLEAR, 32'h0000_000f);
        xfer_pending <= 1'b0;
        stop_req <= 1'b0;
        repeat (300) @(posedge aclk);
        chk(irq, 1'b0);
        // clock start: stopped clock, then receive data waiting
        stop_req <= 1'b1;
        repeat (400) @(posedge aclk);
        chk(rx_clk_sel_crystal, 1'b1);
        rx_data_ready <= 1'b1;
        wait_oe(1'b1);
        rx_data_ready <= 1'b0;
        wait_oe(1'b0);
        repeat (4) @(posedge aclk);
        chk(rx_clk_sel_crystal, 1'b0);
        rd(STS, (32'h0000_0001 << `PCRR_IRQ_START) | REL, OK);
        rd(CTRL, ST | EN | CR, OK);
        wr(CTRL, ST | EN | CR);
        rd(CTRL, EN | CR, OK);
        // interrupt left pending must not hold the clock; the model needs its four edges first
        stop_req <= 1'b0;
        repeat (150) @(posedge aclk);
        stop_req <= 1'b1;
        repeat (600) @(posedge aclk);
        chk(irq, 1'b1);
        chk(clock_run_signal_oe, 1'b0);
        stop_req <= 1'b0;
        repeat (200) @(posedge aclk);
        // no request with wake enable clear; the pin really is released here
        wr(CTRL, CR);
        xfer_pending <= 1'b1;
        stop_req <= 1'b1;
        repeat (600) @(posedge aclk);
        chk(clock_run_signal_oe, 1'b0);
        stop_req <= 1'b0;
        xfer_pending <= 1'b0;
        repeat (100) @(posedge aclk);
        // plain wake output mode
        wr(CTRL, EN);
        wake_on_lan_state <= 1'b1;
        wake_packet <= 1'b1;
        @(posedge aclk);
        wake_packet <= 1'b0;
        repeat (6) @(posedge aclk);
        chk(clock_run_signal_oe, 1'b1);
        chk(rx_clk_sel_crystal, 1'b0);
        wr(CTRL, 32'h0000_0000);
        repeat (4) @(posedge aclk);
        chk(clock_run_signal_oe, 1'b0);
        rd(CTRL, ST, OK);
        // config-space side of the mirror
        cfg_wake_status_clr <= 1'b1;
        cfg_wake_enable <= 1'b1;
        cfg_wr <= 1'b1;
        @(posedge aclk);
        cfg_wr <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(CTRL, EN, OK);
        chk(power_mgmt_wake_status, 1'b0);
        end_sim();
    end
endmodule // tb_pci_clock_run_request
